// ### src/afc_crc_pll_tx_freq_regs.sv
module afc_crc_pll_tx_freq_regs (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // AXI4-Lite write address
  input  wire logic [31:0] i_awaddr,
  input  wire logic [2:0]  i_awprot,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] i_araddr,
  input  wire logic [2:0]  i_arprot,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Frequency correction and gain
  output logic             o_auto_freq_correct_enable,
  output logic [1:0]       o_gain_control_select,
  // CRC
  output logic [30:0]      o_crc_generator_coeffs,
  // Synthesizer
  output logic             o_div_source_select,
  output logic             o_second_synth_halving,
  output logic [1:0]       o_synth_output_divide,
  output logic [2:0]       o_synth_div_ratio,
  // Transmit frequency
  output logic [5:0]       o_tx_integer_count,
  output logic [19:0]      o_tx_fraction_count
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_meta_reg;
  logic rst_n;

  // Async assert, synchronous release keeps all flops leaving reset together
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Address decode
  // ==========================================================
  reg_bus_if bus ();

  // Maps a byte address to a storage slot; unmapped gives all ones
  function automatic logic [3:0] addr_slot(input logic [31:0] addr);
    logic [29:0] word;
    word = addr[31:2];
    if ((word >= 30'(regs_pkg::IDX_RESERVED_A)) && (word <= 30'(regs_pkg::IDX_TX_FRAC_LOW))) begin
      addr_slot = 4'(word - 30'(regs_pkg::IDX_RESERVED_A));
    end else begin
      addr_slot = 4'hF;
    end
  endfunction

  function automatic logic slot_mapped(input logic [3:0] slot);
    slot_mapped = (slot < 4'(regs_pkg::REG_COUNT));
  endfunction

  // ==========================================================
  // Write channel
  // ==========================================================
  logic        aw_have_reg;
  logic [31:0] aw_addr_reg;
  logic        w_have_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane_reg;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic [31:0] wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_lane;
  logic [3:0]  wr_slot;

  assign o_awready = !aw_have_reg && !o_bvalid;
  assign o_wready  = !w_have_reg && !o_bvalid;
  assign aw_take   = i_awvalid && o_awready;
  assign w_take    = i_wvalid && o_wready;

  // Address and data may arrive in either order or together
  assign wr_addr = aw_have_reg ? aw_addr_reg : i_awaddr;
  assign wr_byte = w_have_reg ? w_data_reg : i_wdata[7:0];
  assign wr_lane = w_have_reg ? w_lane_reg : i_wstrb[0];
  assign wr_slot = addr_slot(wr_addr);
  assign wr_fire = (aw_have_reg || aw_take) && (w_have_reg || w_take) && !o_bvalid;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end else if (aw_take) begin
      aw_have_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_reg <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_addr_reg <= i_awaddr;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_reg <= 1'b0;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end else if (w_take) begin
      w_have_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (w_take) begin
      w_data_reg <= i_wdata[7:0];
      w_lane_reg <= i_wstrb[0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bvalid <= 1'b0;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bresp <= regs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_bresp <= slot_mapped(wr_slot) ? regs_pkg::RESP_OKAY : regs_pkg::RESP_SLVERR;
    end
  end

  // byte lane zero carries the register, upper lanes are ignored
  assign bus.wr_en   = wr_fire && wr_lane && slot_mapped(wr_slot);
  assign bus.wr_slot = wr_slot;
  assign bus.wr_data = wr_byte;

  // ==========================================================
  // Read channel
  // ==========================================================
  regs_pkg::rd_state_t rd_state_reg;
  logic                ar_take;
  logic [3:0]          rd_slot;

  assign o_arready = (rd_state_reg == regs_pkg::RD_IDLE);
  assign ar_take   = i_arvalid && o_arready;
  assign rd_slot   = addr_slot(i_araddr);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_reg <= regs_pkg::RD_IDLE;
    end else begin
      case (rd_state_reg)
        regs_pkg::RD_IDLE: begin
          if (ar_take) begin
            rd_state_reg <= regs_pkg::RD_RESP;
          end
        end
        regs_pkg::RD_RESP: begin
          if (i_rready) begin
            rd_state_reg <= regs_pkg::RD_IDLE;
          end
        end
        default: rd_state_reg <= regs_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rresp <= regs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      o_rresp <= slot_mapped(rd_slot) ? regs_pkg::RESP_OKAY : regs_pkg::RESP_SLVERR;
    end
  end

  assign bus.rd_en   = ar_take;
  assign bus.rd_slot = rd_slot;
  assign o_rvalid    = (rd_state_reg == regs_pkg::RD_RESP);
  // Storage read register only changes on a new read, so data stand until rready
  assign o_rdata     = {24'h00_0000, bus.rd_data};

  // ==========================================================
  // Register storage
  // ==========================================================
  reg_storage u_storage (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .bus     (bus)
  );

  // ==========================================================
  // Field decode
  // ==========================================================
  function automatic logic [7:0] slot_byte(input logic [87:0] image, input logic [7:0] idx);
    slot_byte = image[8*(idx - regs_pkg::IDX_RESERVED_A) +: 8];
  endfunction

  logic [7:0]  freq_gain_byte;
  logic [7:0]  crc_byte3;
  logic [7:0]  crc_byte2;
  logic [7:0]  crc_byte1;
  logic [7:0]  crc_byte0;
  logic [7:0]  synth_div_byte;
  logic [7:0]  tx_integer_byte;
  logic [7:0]  tx_frac_high_byte;
  logic [7:0]  tx_frac_mid_byte;
  logic [7:0]  tx_frac_low_byte;
  logic [1:0]  gain_effective;
  logic [2:0]  ratio;
  logic [30:0] crc_coeffs_next;
  logic [5:0]  tx_integer_next;
  logic [19:0] tx_fraction_next;

  assign freq_gain_byte    = slot_byte(bus.image, regs_pkg::IDX_FREQ_GAIN);
  assign crc_byte3         = slot_byte(bus.image, regs_pkg::IDX_CRC_BYTE3);
  assign crc_byte2         = slot_byte(bus.image, regs_pkg::IDX_CRC_BYTE2);
  assign crc_byte1         = slot_byte(bus.image, regs_pkg::IDX_CRC_BYTE1);
  assign crc_byte0         = slot_byte(bus.image, regs_pkg::IDX_CRC_BYTE0);
  assign synth_div_byte    = slot_byte(bus.image, regs_pkg::IDX_SYNTH_DIV);
  assign tx_integer_byte   = slot_byte(bus.image, regs_pkg::IDX_TX_INTEGER);
  assign tx_frac_high_byte = slot_byte(bus.image, regs_pkg::IDX_TX_FRAC_HIGH);
  assign tx_frac_mid_byte  = slot_byte(bus.image, regs_pkg::IDX_TX_FRAC_MID);
  assign tx_frac_low_byte  = slot_byte(bus.image, regs_pkg::IDX_TX_FRAC_LOW);

  // ==========================================================
  // Field assembly
  // ==========================================================
  // polynomial assembly, top reserved bit dropped
  assign crc_coeffs_next  = {crc_byte3[6:0], crc_byte2, crc_byte1, crc_byte0};
  assign tx_integer_next  = tx_integer_byte[5:0];
  assign tx_fraction_next = {tx_frac_high_byte[3:0], tx_frac_mid_byte, tx_frac_low_byte};

  // Reserved gain code falls back to switching so the gain loop never sees it
  always_comb begin
    case (freq_gain_byte[1:0])
      regs_pkg::GAIN_HIGH_FIXED: gain_effective = regs_pkg::GAIN_HIGH_FIXED;
      regs_pkg::GAIN_SWITCHING:  gain_effective = regs_pkg::GAIN_SWITCHING;
      regs_pkg::GAIN_LOW_FIXED:  gain_effective = regs_pkg::GAIN_LOW_FIXED;
      default:                   gain_effective = regs_pkg::GAIN_SWITCHING;
    endcase
  end

  synth_div_select u_div_select (
    .i_config (synth_div_byte),
    .o_ratio  (ratio)
  );

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_auto_freq_correct_enable <= regs_pkg::RST_FREQ_GAIN[regs_pkg::POS_CORRECT_EN];
    end else begin
      o_auto_freq_correct_enable <= freq_gain_byte[regs_pkg::POS_CORRECT_EN];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_gain_control_select <= regs_pkg::RST_FREQ_GAIN[1:0];
    end else begin
      o_gain_control_select <= gain_effective;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_crc_generator_coeffs <= {regs_pkg::RST_CRC_BYTE3[6:0], regs_pkg::RST_CRC_BYTE2,
                                 regs_pkg::RST_CRC_BYTE1, regs_pkg::RST_CRC_BYTE0};
    end else begin
      o_crc_generator_coeffs <= crc_coeffs_next;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_div_source_select    <= regs_pkg::RST_SYNTH_DIV[regs_pkg::POS_DIV_SOURCE];
      o_second_synth_halving <= regs_pkg::RST_SYNTH_DIV[regs_pkg::POS_HALVING];
      o_synth_output_divide  <= regs_pkg::RST_SYNTH_DIV[1:0];
    end else begin
      o_div_source_select    <= synth_div_byte[regs_pkg::POS_DIV_SOURCE];
      o_second_synth_halving <= synth_div_byte[regs_pkg::POS_HALVING];
      o_synth_output_divide  <= synth_div_byte[1:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_synth_div_ratio <= regs_pkg::RATIO_SIX;
    end else begin
      o_synth_div_ratio <= ratio;
    end
  end

  // reset values give the default channel with divide by six
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_integer_count <= regs_pkg::RST_TX_INTEGER[5:0];
    end else begin
      o_tx_integer_count <= tx_integer_next;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_fraction_count <= {regs_pkg::RST_TX_FRAC_HIGH[3:0], regs_pkg::RST_TX_FRAC_MID,
                              regs_pkg::RST_TX_FRAC_LOW};
    end else begin
      o_tx_fraction_count <= tx_fraction_next;
    end
  end

endmodule

// ### src/reg_bus_if.sv
interface reg_bus_if;
  logic        wr_en;
  logic [3:0]  wr_slot;
  logic [7:0]  wr_data;
  logic        rd_en;
  logic [3:0]  rd_slot;
  logic [7:0]  rd_data;
  logic [87:0] image;

  modport ctrl (output wr_en, wr_slot, wr_data, rd_en, rd_slot, input rd_data, image);
  modport mem  (input wr_en, wr_slot, wr_data, rd_en, rd_slot, output rd_data, image);
endinterface

// ### src/reg_storage.sv
module reg_storage (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Access port
  reg_bus_if.mem    bus
);

  logic [7:0] slot_reg [regs_pkg::REG_COUNT];

  // ==========================================================
  // Storage
  // ==========================================================
  for (genvar n = 0; n < regs_pkg::REG_COUNT; n++) begin : g_slot
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        slot_reg[n] <= regs_pkg::slot_reset(n);
      end else if (bus.wr_en && (bus.wr_slot == 4'(n))) begin
        slot_reg[n] <= bus.wr_data;
      end
    end
    assign bus.image[8*n +: 8] = slot_reg[n];
  end

  // Read data held until the next read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus.rd_data <= 8'h00;
    end else if (bus.rd_en) begin
      bus.rd_data <= (bus.rd_slot < 4'(regs_pkg::REG_COUNT)) ? slot_reg[bus.rd_slot] : 8'h00;
    end
  end

endmodule

// ### src/regs_pkg.sv
package regs_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  // ==========================================================
  localparam logic [7:0] IDX_RESERVED_A   = 8'h14;
  localparam logic [7:0] IDX_FREQ_GAIN    = 8'h15;
  localparam logic [7:0] IDX_CRC_BYTE3    = 8'h16;
  localparam logic [7:0] IDX_CRC_BYTE2    = 8'h17;
  localparam logic [7:0] IDX_CRC_BYTE1    = 8'h18;
  localparam logic [7:0] IDX_CRC_BYTE0    = 8'h19;
  localparam logic [7:0] IDX_SYNTH_DIV    = 8'h1A;
  localparam logic [7:0] IDX_TX_INTEGER   = 8'h1B;
  localparam logic [7:0] IDX_TX_FRAC_HIGH = 8'h1C;
  localparam logic [7:0] IDX_TX_FRAC_MID  = 8'h1D;
  localparam logic [7:0] IDX_TX_FRAC_LOW  = 8'h1E;
  localparam int         REG_COUNT        = 11;
  localparam int         SLOT_W           = 4;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_RESERVED_A   = 8'h00;
  localparam logic [7:0] RST_FREQ_GAIN    = 8'h81;
  localparam logic [7:0] RST_CRC_BYTE3    = 8'h00;
  localparam logic [7:0] RST_CRC_BYTE2    = 8'h00;
  localparam logic [7:0] RST_CRC_BYTE1    = 8'h1E;
  localparam logic [7:0] RST_CRC_BYTE0    = 8'hB2;
  localparam logic [7:0] RST_SYNTH_DIV    = 8'h01;
  localparam logic [7:0] RST_TX_INTEGER   = 8'h2A;
  localparam logic [7:0] RST_TX_FRAC_HIGH = 8'h05;
  localparam logic [7:0] RST_TX_FRAC_MID  = 8'hA0;
  localparam logic [7:0] RST_TX_FRAC_LOW  = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int POS_CORRECT_EN  = 7;
  localparam int POS_DIV_SOURCE  = 6;
  localparam int POS_HALVING     = 4;

  // ==========================================================
  // Encodings
  // ==========================================================
  localparam logic [1:0] GAIN_HIGH_FIXED = 2'h0;
  localparam logic [1:0] GAIN_SWITCHING  = 2'h1;
  localparam logic [1:0] GAIN_LOW_FIXED  = 2'h2;
  localparam logic [1:0] DIV_NONE        = 2'h0;
  localparam logic [1:0] DIV_BY_SIX      = 2'h1;
  localparam logic [1:0] DIV_BY_TWO      = 2'h2;
  localparam logic [2:0] RATIO_ONE       = 3'h1;
  localparam logic [2:0] RATIO_TWO       = 3'h2;
  localparam logic [2:0] RATIO_SIX       = 3'h6;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // Read channel states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;

  // Reset value of storage slot n (slot 0 is index 0x14)
  function automatic logic [7:0] slot_reset(input int n);
    case (n)
      1:       slot_reset = RST_FREQ_GAIN;
      2:       slot_reset = RST_CRC_BYTE3;
      3:       slot_reset = RST_CRC_BYTE2;
      4:       slot_reset = RST_CRC_BYTE1;
      5:       slot_reset = RST_CRC_BYTE0;
      6:       slot_reset = RST_SYNTH_DIV;
      7:       slot_reset = RST_TX_INTEGER;
      8:       slot_reset = RST_TX_FRAC_HIGH;
      9:       slot_reset = RST_TX_FRAC_MID;
      10:      slot_reset = RST_TX_FRAC_LOW;
      default: slot_reset = RST_RESERVED_A;
    endcase
  endfunction

endpackage

// ### src/synth_div_select.sv
module synth_div_select (
  // Configuration byte
  input  wire logic [7:0] i_config,
  // Effective ratio
  output logic      [2:0] o_ratio
);

  logic [1:0] divide_field;

  assign divide_field = i_config[1:0];

  always_comb begin
    o_ratio = regs_pkg::RATIO_ONE;
    if (i_config[regs_pkg::POS_DIV_SOURCE]) begin
      o_ratio = i_config[regs_pkg::POS_HALVING] ? regs_pkg::RATIO_TWO : regs_pkg::RATIO_ONE;
    end else begin
      case (divide_field)
        regs_pkg::DIV_NONE:   o_ratio = regs_pkg::RATIO_ONE;
        regs_pkg::DIV_BY_SIX: o_ratio = regs_pkg::RATIO_SIX;
        regs_pkg::DIV_BY_TWO: o_ratio = regs_pkg::RATIO_TWO;
        default:              o_ratio = regs_pkg::RATIO_ONE;
      endcase
    end
  end

endmodule

// ### verif/afc_crc_pll_tx_freq_regs_assertions.sv
module afc_crc_pll_tx_freq_regs_assertions (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // Register bus
  input wire logic [31:0] i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  // Fields
  input wire logic        o_auto_freq_correct_enable,
  input wire logic [1:0]  o_gain_control_select,
  input wire logic [30:0] o_crc_generator_coeffs,
  input wire logic        o_div_source_select,
  input wire logic        o_second_synth_halving,
  input wire logic [1:0]  o_synth_output_divide,
  input wire logic [2:0]  o_synth_div_ratio
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ========
  // Sequences
  sequence s_write_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_crc_top_write;
    s_write_taken ##0 (i_wstrb[0] && i_awaddr == 32'h58);
  endsequence
  sequence s_unmapped_write;
    s_write_taken ##0 (i_awaddr[31:2] < 30'h14 || i_awaddr[31:2] > 30'h1E);
  endsequence

  // ========
  // Properties
  a_bresp_held: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response changed before acceptance");
  a_rdata_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed before acceptance");
  a_write_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channels ready during response");
  a_read_latency: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer late");
  a_rdata_byte: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_error: assert property (s_unmapped_write |=> o_bvalid && o_bresp == regs_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  // Field outputs lag the stored write by one clock
  a_crc_top_bits: assert property (s_crc_top_write |=> ##1 o_crc_generator_coeffs[30:24] == $past(i_wdata[6:0], 2))
    else $error("polynomial top bits wrong");
  a_gain_no_reserved: assert property (o_gain_control_select != 2'h3)
    else $error("reserved gain code driven");
  a_ratio_select: assert property (o_synth_div_ratio == (o_div_source_select ?
      (o_second_synth_halving ? regs_pkg::RATIO_TWO : regs_pkg::RATIO_ONE) :
      (o_synth_output_divide == regs_pkg::DIV_BY_SIX ? regs_pkg::RATIO_SIX :
      o_synth_output_divide == regs_pkg::DIV_BY_TWO ? regs_pkg::RATIO_TWO : regs_pkg::RATIO_ONE)))
    else $error("division ratio wrong");
  a_reset_fields: assert property ($rose(i_reset_n) |-> o_auto_freq_correct_enable &&
      o_gain_control_select == 2'h1 && o_crc_generator_coeffs == 31'h1EB2 && o_synth_div_ratio == 3'h6)
    else $error("field reset values wrong");
endmodule

bind afc_crc_pll_tx_freq_regs afc_crc_pll_tx_freq_regs_assertions u_checker (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_auto_freq_correct_enable(o_auto_freq_correct_enable),
  .o_gain_control_select(o_gain_control_select), .o_crc_generator_coeffs(o_crc_generator_coeffs),
  .o_div_source_select(o_div_source_select), .o_second_synth_halving(o_second_synth_halving),
  .o_synth_output_divide(o_synth_output_divide), .o_synth_div_ratio(o_synth_div_ratio)
);

// ### verif/test_afc_crc_pll_tx_freq_regs.sv
module test_afc_crc_pll_tx_freq_regs;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [1:0]  resp;
    logic [31:0] rdata;
  } row_t;

  // ========
  // Signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, corr_en, div_src, halving;
  logic [1:0]  bresp, rresp, gain, divide, resp;
  logic [31:0] rdata, data;
  logic [30:0] crc;
  logic [2:0]  ratio;
  logic [5:0]  tx_int;
  logic [19:0] tx_frac;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  row_t        rows [12];
  logic [7:0]  rst_vals [11] = '{8'h00, 8'h81, 8'h00, 8'h00, 8'h1E, 8'hB2, 8'h01, 8'h2A, 8'h05, 8'hA0, 8'h00};
  logic [7:0]  cfg [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h41, 8'h50, 8'h53, 8'hED};
  logic [2:0]  cfg_ratio [8] = '{3'h1, 3'h6, 3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1};

  afc_crc_pll_tx_freq_regs DUT (
    .i_clk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr), .i_awprot(3'h0), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arprot(3'h0),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_auto_freq_correct_enable(corr_en), .o_gain_control_select(gain),
    .o_crc_generator_coeffs(crc), .o_div_source_select(div_src), .o_second_synth_halving(halving),
    .o_synth_output_divide(divide), .o_synth_div_ratio(ratio), .o_tx_integer_count(tx_int),
    .o_tx_fraction_count(tx_frac)
  );

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  // ========
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Internal reset needs two edges to clear before the first request
    repeat (3) @(posedge clk);
  endtask

  // Stall holds the response ready low for that many cycles
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input int stall,
                           output logic [1:0] r);
    int k;
    k = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    forever begin
      @(posedge clk);
      k++;
      if (bready && bvalid) begin
        r = bresp;
        break;
      end
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (k == stall) bready <= 1'b1;
    end
  endtask

  task automatic axi_read(input logic [31:0] a, input int stall, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (stall == 0);
    forever begin
      @(posedge clk);
      k++;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
      if (arvalid && arready) arvalid <= 1'b0;
      if (k == stall) rready <= 1'b1;
    end
  endtask

  task automatic check_resets;
    for (int i = 0; i < 11; i++) begin
      axi_read(32'h50 + 32'(4 * i), 0, data, resp);
      check("reset value", data, {24'h0, rst_vals[i]});
    end
    check("enable", 32'(corr_en), 32'h1);
    check("gain mode", 32'(gain), 32'h1);
    check("crc", 32'(crc), 32'h0000_1EB2);
    check("divide", 32'(divide), 32'h1);
    check("ratio", 32'(ratio), 32'h6);
    check("tx integer", 32'(tx_int), 32'h2A);
    check("tx fraction", 32'(tx_frac), 32'h0005_A000);
  endtask

  // ========
  // Sequence of tests
  initial begin
    rows = '{'{32'h50, 32'hFFFF_FF5A, 4'hF, 2'h0, 32'h5A}, '{32'h58, 32'hFF, 4'h1, 2'h0, 32'hFF},
             '{32'h5C, 32'h12, 4'h1, 2'h0, 32'h12}, '{32'h60, 32'h34, 4'h1, 2'h0, 32'h34},
             '{32'h64, 32'h56, 4'h1, 2'h0, 32'h56}, '{32'h6C, 32'hFF, 4'h1, 2'h0, 32'hFF},
             '{32'h70, 32'hA7, 4'h1, 2'h0, 32'hA7}, '{32'h74, 32'h3C, 4'h1, 2'h0, 32'h3C},
             '{32'h78, 32'hC5, 4'h1, 2'h0, 32'hC5}, '{32'h54, 32'h00, 4'hE, 2'h0, 32'h81},
             '{32'h4C, 32'h11, 4'h1, 2'h2, 32'h0}, '{32'h7C, 32'h11, 4'h1, 2'h2, 32'h0}};
    do_reset();
    check_resets();
    foreach (rows[i]) begin
      axi_write(rows[i].addr, rows[i].wdata, rows[i].strb, i % 3, resp);
      check("write resp", 32'(resp), 32'(rows[i].resp));
      axi_read(rows[i].addr, (i + 1) % 3, data, resp);
      check("read data", data, rows[i].rdata);
      check("read resp", 32'(resp), 32'(rows[i].resp));
    end
    check("crc", 32'(crc), 32'h7F12_3456);
    check("tx integer", 32'(tx_int), 32'h3F);
    check("tx fraction", 32'(tx_frac), 32'h0007_3CC5);
    // Read back first so the field outputs have settled before sampling
    for (int c = 0; c < 4; c++) begin
      axi_write(32'h54, 32'(c) | 32'((c % 2) * 128), 4'h1, 0, resp);
      axi_read(32'h54, 0, data, resp);
      check("gain reg", data, 32'(c) | 32'((c % 2) * 128));
      check("enable", 32'(corr_en), 32'(c % 2));
      check("gain mode", 32'(gain), 32'(c == 3 ? 1 : c));
    end
    foreach (cfg[i]) begin
      axi_write(32'h68, {24'h0, cfg[i]}, 4'h1, 1, resp);
      axi_read(32'h68, 0, data, resp);
      check("divider reg", data, {24'h0, cfg[i]});
      check("divider", 32'({div_src, halving, divide, ratio}),
            32'({cfg[i][6], cfg[i][4], cfg[i][1:0], cfg_ratio[i]}));
    end
    do_reset();
    check_resets();
    end_sim();
  end
endmodule
